// ==== hw/mcsp_main_clock.sv ====
// Contract
// [RL1] pin enable bit 7 puts the system clock on the output pin
// [RL2] during sleep the pin is quiet unless a peripheral uses the clock
// [RL3] two-bit select picks fast, ultra-low-power, crystal or external source
// [RL4] divider codes 0x0..0x5 divide by 2, 4, 8, 16, 32, 64
// [RL5] codes 0x8..0xC divide by 6, 10, 12, 24, 48; others reserved
// [RL6] divider writes take effect while running, no stop needed
// [RL7] prescaler off passes main clock undivided, on applies the divider
// [RL8] software keeps peripheral clock under its limit; not checked here
// [RL9] lock freezes source, prescaler and active source calibration
// [RL10] once locked, lock register refuses access until hardware reset
// [RL11] lock bit loads from fuse lock bit at reset
// [RL12] status bits 7..4 report external, crystal, ulp, fast stability
// [RL13] stability flag reads 0 unless that source is requested
// [RL14] status bit 0 high while a switch waits for the new source
// [RL15] fast run-in-standby keeps the fast oscillator powered always
// [RL16] unrequested oscillator gives no clock even if running
// [RL17] gate opens four oscillator cycles after request
// [RL18] fast trim loads a factory value chosen by fuse frequency select
// [RL19] software writes the unlock key before protected writes
// [RL20] protected writes without unlock leave registers unchanged
// [RL21] main mux switches glitch free once the new source is stable
// [RL22] while locked, frozen registers ignore writes and read back held values
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "mcsp_cfg.svh"

module mcsp_main_clock
    import mcsp_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       change_protection,
    input  wire logic       fuse_calibration_lock,
    input  wire logic       fuse_frequency_select,
    input  wire logic [6:0] factory_trim_lo,
    input  wire logic [6:0] factory_trim_hi,
    input  wire logic [3:0] factory_temp_lo,
    input  wire logic [3:0] factory_temp_hi,
    input  wire logic [3:0] osc_level,
    input  wire logic [3:0] osc_ready,
    input  wire logic [3:0] periph_request,
    input  wire logic       sleep_active,
    input  wire logic       periph_uses_sysclk,
    output logic            main_clock,
    output logic            peripheral_clock,
    output logic            system_clock_pin,
    output logic            fast_osc_power,
    output logic            ulp_osc_power,
    output logic            crystal_osc_power,
    output logic            crystal_ext_select,
    output logic      [1:0] crystal_startup_sel
);

    // ****************************************
    // decode helpers
    // ****************************************
    // half of the division ratio; divide by 64 needs six bits
    function automatic logic [5:0] half_ratio(input logic [3:0] code);
        logic [5:0] h;
        h = 6'h01;
        unique case (code)
            4'h0: h = 6'h01;
            4'h1: h = 6'h02;
            4'h2: h = 6'h04;
            4'h3: h = 6'h08;
            4'h4: h = 6'h10;
            4'h5: h = 6'h20;
            4'h8: h = 6'h03;
            4'h9: h = 6'h05;
            4'hA: h = 6'h06;
            4'hB: h = 6'h0C;
            4'hC: h = 6'h18;
            default: h = 6'h01;
        endcase
        return h;
    endfunction

    function automatic logic [3:0] src_onehot(input logic [1:0] s);
        return 4'h1 << s;
    endfunction

    mcsp_state_t st_r;
    mcsp_state_t st_nxt;

    logic [3:0] requested;
    logic [3:0] rise;
    logic [3:0] lvl_new;
    logic [3:0] stable;
    logic [1:0] target;
    logic       wr_ok;
    logic       cal_locked;
    logic       main_new;
    logic       main_rise;
    logic [5:0] half;
    logic [7:0] status;
    logic [7:0] rd_val;
    logic       xtal_busy;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;

        // three-stage sampling, change accepted when last two agree
        st_nxt.sync1 = osc_level;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.rdy1  = osc_ready;
        st_nxt.rdy2  = st_r.rdy1;
        st_nxt.rdy3  = st_r.rdy2;
        for (int i = 0; i < 4; i++) begin
            lvl_new[i] = (st_r.sync2[i] == st_r.sync3[i]) ? st_r.sync3[i] : st_r.filt[i];
            if (st_r.rdy2[i] == st_r.rdy3[i]) begin
                st_nxt.rdy[i] = st_r.rdy3[i];
            end
        end
        st_nxt.filt = lvl_new;
        rise        = lvl_new & ~st_r.filt;

        target    = st_r.main_src[1:0];                                     // [RL3]
        requested = src_onehot(target) | src_onehot(st_r.active) | periph_request;

        // clock gates: closed when unrequested, open after four edges
        for (int i = 0; i < 4; i++) begin
            if (!requested[i] || !st_r.rdy[i]) begin                        // [RL16]
                st_nxt.gate_cnt[i*3 +: 3] = 3'h0;
                st_nxt.gate_open[i]       = 1'b0;
            end else if (!st_r.gate_open[i] && rise[i]) begin
                st_nxt.gate_cnt[i*3 +: 3] = st_r.gate_cnt[i*3 +: 3] + 3'h1;
                if (st_r.gate_cnt[i*3 +: 3] + 3'h1 == `MCSP_GATE_CYCLES) begin  // [RL17]
                    st_nxt.gate_open[i] = 1'b1;
                end
            end
        end
        stable = requested & st_r.rdy & st_r.gate_open;                     // [RL13]

        // glitch-free source switch
        unique case (st_r.sw)
            SW_IDLE: begin
                if (target != st_r.active) begin
                    st_nxt.sw = SW_WAIT;
                end
            end
            SW_WAIT: begin
                if (target == st_r.active) begin
                    st_nxt.sw = SW_IDLE;
                end else if (stable[target] && !st_r.main_lvl && !lvl_new[target]) begin
                    st_nxt.active = target;                                 // [RL21]
                    st_nxt.sw     = SW_IDLE;                                // [RL14]
                end
            end
        endcase

        main_new        = st_r.gate_open[st_r.active] ? lvl_new[st_r.active] : 1'b0;
        st_nxt.main_lvl = main_new;
        main_rise       = main_new & ~st_r.main_lvl;

        // prescaler, ratio re-read every edge so run-time writes apply
        half = half_ratio(st_r.prescale[4:1]);                              // [RL4] [RL5]
        if (main_rise) begin
            if ({1'b0, st_r.div_cnt} + 6'h01 >= half) begin                 // [RL6]
                st_nxt.div_cnt = 5'h00;
                st_nxt.div_lvl = ~st_r.div_lvl;
            end else begin
                st_nxt.div_cnt = st_r.div_cnt + 5'h01;
            end
        end
        st_nxt.per_lvl = st_r.prescale[`MCSP_BIT_PRE_ON] ? st_nxt.div_lvl : main_new;  // [RL7]

        st_nxt.pin_lvl = st_r.main_src[`MCSP_BIT_PIN_EN]                    // [RL1]
                       && (!sleep_active || periph_uses_sysclk)             // [RL2]
                       && main_new;

        // register writes
        wr_ok      = reg_wr && change_protection;                           // [RL20]
        cal_locked = fuse_calibration_lock
                   || (st_r.lock && st_r.active == `MCSP_SRC_FAST);         // [RL9]
        xtal_busy  = st_r.xtal_ctrl[`MCSP_BIT_XTAL_EN] || stable[`MCSP_SRC_XTAL];
        if (wr_ok) begin
            unique case (reg_addr)
                `MCSP_OFS_MAIN_SRC: begin
                    if (!st_r.lock) begin                                   // [RL22]
                        st_nxt.main_src = reg_wdata & 8'h83;
                    end
                end
                `MCSP_OFS_PRESCALE: begin
                    if (!st_r.lock) begin                                   // [RL9]
                        st_nxt.prescale = reg_wdata & 8'h1F;
                    end
                end
                `MCSP_OFS_LOCK: begin
                    if (!st_r.lock) begin                                   // [RL10]
                        st_nxt.lock = reg_wdata[`MCSP_BIT_LOCK];
                    end
                end
                `MCSP_OFS_FAST_CTRL: begin
                    st_nxt.fast_stby = reg_wdata[`MCSP_BIT_RUN_STBY];
                end
                `MCSP_OFS_FAST_TRIM: begin
                    if (!cal_locked) begin                                  // [RL22]
                        st_nxt.fast_trim = reg_wdata[6:0];
                    end
                end
                `MCSP_OFS_FAST_TEMP: begin
                    if (!cal_locked) begin
                        st_nxt.fast_temp = reg_wdata[3:0];
                    end
                end
                `MCSP_OFS_ULP_CTRL: begin
                    st_nxt.ulp_stby = reg_wdata[`MCSP_BIT_RUN_STBY];
                end
                `MCSP_OFS_XTAL_CTRL: begin
                    st_nxt.xtal_ctrl[1:0] = reg_wdata[1:0];
                    if (!xtal_busy) begin
                        st_nxt.xtal_ctrl[5:2] = reg_wdata[5:2] & 4'hD;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads
        status = {stable[`MCSP_SRC_EXT], stable[`MCSP_SRC_XTAL],           // [RL12]
                  stable[`MCSP_SRC_ULP], stable[`MCSP_SRC_FAST], 4'h0};
        status[`MCSP_BIT_SW_PEND] = (st_r.sw == SW_WAIT);                   // [RL14]
        rd_val = 8'h00;
        unique case (reg_addr)
            `MCSP_OFS_MAIN_SRC:  rd_val = st_r.main_src;
            `MCSP_OFS_PRESCALE:  rd_val = st_r.prescale;
            `MCSP_OFS_LOCK:      rd_val = {7'h00, st_r.lock} & {8{!st_r.lock}};  // [RL10]
            `MCSP_OFS_STATUS:    rd_val = status;
            `MCSP_OFS_FAST_CTRL: rd_val = {6'h00, st_r.fast_stby, 1'b0};
            `MCSP_OFS_FAST_TRIM: rd_val = {1'b0, st_r.fast_trim};
            `MCSP_OFS_FAST_TEMP: rd_val = {fuse_calibration_lock, 3'h0, st_r.fast_temp};
            `MCSP_OFS_ULP_CTRL:  rd_val = {6'h00, st_r.ulp_stby, 1'b0};
            `MCSP_OFS_XTAL_CTRL: rd_val = st_r.xtal_ctrl;
            default:             rd_val = 8'h00;
        endcase
        st_nxt.rdata = reg_rd ? rd_val : 8'h00;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.sw        <= SW_IDLE;
            st_r.active    <= `MCSP_SRC_FAST;
            st_r.main_src  <= `MCSP_RST_MAIN_SRC;
            st_r.prescale  <= `MCSP_RST_PRESCALE;
            st_r.xtal_ctrl <= `MCSP_RST_CTRL;
            st_r.lock      <= fuse_calibration_lock;                        // [RL11]
            st_r.fast_trim <= fuse_frequency_select ? factory_trim_hi : factory_trim_lo;  // [RL18]
            st_r.fast_temp <= fuse_frequency_select ? factory_temp_hi : factory_temp_lo;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata           = st_r.rdata;
    assign main_clock          = st_r.main_lvl;
    assign peripheral_clock    = st_r.per_lvl;
    assign system_clock_pin    = st_r.pin_lvl;
    assign fast_osc_power      = st_r.fast_stby || requested[`MCSP_SRC_FAST];  // [RL15]
    assign ulp_osc_power       = st_r.ulp_stby || requested[`MCSP_SRC_ULP];
    assign crystal_osc_power   = st_r.xtal_ctrl[`MCSP_BIT_XTAL_EN]
                               && (st_r.xtal_ctrl[`MCSP_BIT_RUN_STBY] || requested[`MCSP_SRC_XTAL]);
    assign crystal_ext_select  = st_r.xtal_ctrl[`MCSP_BIT_XTAL_SEL];
    assign crystal_startup_sel = st_r.xtal_ctrl[5:4];

endmodule

// ==== hw/mcsp_cfg.svh ====
`ifndef MCSP_CFG_SVH
`define MCSP_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define MCSP_OFS_MAIN_SRC   5'h00
`define MCSP_OFS_PRESCALE   5'h01
`define MCSP_OFS_LOCK       5'h02
`define MCSP_OFS_STATUS     5'h03
`define MCSP_OFS_FAST_CTRL  5'h10
`define MCSP_OFS_FAST_TRIM  5'h11
`define MCSP_OFS_FAST_TEMP  5'h12
`define MCSP_OFS_ULP_CTRL   5'h18
`define MCSP_OFS_XTAL_CTRL  5'h1C

// ****************************************
// field positions
// ****************************************
`define MCSP_BIT_PIN_EN     7
`define MCSP_BIT_PRE_ON     0
`define MCSP_BIT_LOCK       0
`define MCSP_BIT_RUN_STBY   1
`define MCSP_BIT_XTAL_EN    0
`define MCSP_BIT_XTAL_SEL   2
`define MCSP_BIT_FUSE_LOCK  7
`define MCSP_BIT_SW_PEND    0
`define MCSP_BIT_FAST_STB   4

// ****************************************
// reset values
// ****************************************
`define MCSP_RST_MAIN_SRC   8'h00
`define MCSP_RST_PRESCALE   8'h11
`define MCSP_RST_CTRL       8'h00

// ****************************************
// source codes and timing
// ****************************************
`define MCSP_SRC_FAST       2'h0
`define MCSP_SRC_ULP        2'h1
`define MCSP_SRC_XTAL       2'h2
`define MCSP_SRC_EXT        2'h3
`define MCSP_GATE_CYCLES    3'h4

`endif

// ==== hw/mcsp_pkg.sv ====
package mcsp_pkg;

    typedef enum logic {
        SW_IDLE,
        SW_WAIT
    } mcsp_sw_t;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  sync3;
        logic [3:0]  filt;
        logic [3:0]  rdy1;
        logic [3:0]  rdy2;
        logic [3:0]  rdy3;
        logic [3:0]  rdy;
        logic [11:0] gate_cnt;
        logic [3:0]  gate_open;
        mcsp_sw_t    sw;
        logic [1:0]  active;
        logic [7:0]  main_src;
        logic [7:0]  prescale;
        logic        lock;
        logic        fast_stby;
        logic [6:0]  fast_trim;
        logic [3:0]  fast_temp;
        logic        ulp_stby;
        logic [7:0]  xtal_ctrl;
        logic        main_lvl;
        logic [4:0]  div_cnt;
        logic        div_lvl;
        logic        per_lvl;
        logic        pin_lvl;
        logic [7:0]  rdata;
    } mcsp_state_t;

endpackage

// ==== tb/mcsp_main_clock_sva.sv ====
`timescale 1ns/1ns
`include "mcsp_cfg.svh"

module mcsp_main_clock_sva (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       change_protection,
    input wire logic       fuse_calibration_lock,
    input wire logic       sleep_active,
    input wire logic       periph_uses_sysclk,
    input wire logic       main_clock,
    input wire logic       system_clock_pin,
    input wire logic       fast_osc_power
);
    // ****
    // shadow copies of the software view
    // ****
    logic       lock_r;
    logic [7:0] src_r;
    logic [4:0] pre_r;
    logic       stby_r;
    logic       wr_ok;

    assign wr_ok = reg_wr && change_protection;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lock_r <= fuse_calibration_lock;
            src_r  <= 8'h00;
            pre_r  <= 5'h11;
            stby_r <= 1'b0;
        end else begin
            if (wr_ok && !lock_r && reg_addr == `MCSP_OFS_LOCK) begin
                lock_r <= reg_wdata[0];
            end
            if (wr_ok && !lock_r && reg_addr == `MCSP_OFS_MAIN_SRC) begin
                src_r <= reg_wdata & 8'h83;
            end
            if (wr_ok && !lock_r && reg_addr == `MCSP_OFS_PRESCALE) begin
                pre_r <= reg_wdata[4:0];
            end
            if (wr_ok && reg_addr == `MCSP_OFS_FAST_CTRL) begin
                stby_r <= reg_wdata[1];
            end
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_rd(logic [4:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_quiet;
        (sleep_active && !periph_uses_sysclk)[*2];
    endsequence

    chk_pin_off: assert property ((!src_r[`MCSP_BIT_PIN_EN])[*2] |-> !system_clock_pin)
        else $error("clock pin active while disabled");
    chk_pin_sleep: assert property (s_quiet |-> !system_clock_pin)
        else $error("clock pin active in sleep");
    chk_src_read: assert property (s_rd(`MCSP_OFS_MAIN_SRC) |=> reg_rdata == src_r)
        else $error("source select readback wrong");
    chk_pre_held: assert property (s_rd(`MCSP_OFS_PRESCALE) |=> reg_rdata == {3'h0, pre_r})
        else $error("prescaler readback wrong");
    chk_lock_hidden: assert property (s_rd(`MCSP_OFS_LOCK) |=> reg_rdata == 8'h00)
        else $error("lock register readable");
    chk_status_rsvd: assert property (s_rd(`MCSP_OFS_STATUS) |=> reg_rdata[3:1] == 3'h0)
        else $error("status unused bits set");
    chk_stby_power: assert property (stby_r |-> fast_osc_power)
        else $error("fast oscillator unpowered in standby run");
    chk_gate_late: assert property ($rose(rst_n) |-> (!main_clock)[*8])
        else $error("main clock gate opened too early");
endmodule

// ==== tb/tb_main_clock_select_prescaler.sv ====
`timescale 1ns/1ns
`include "mcsp_cfg.svh"

module tb_main_clock_select_prescaler;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        change_protection = 1'b0;
    logic        fuse_calibration_lock = 1'b0;
    logic        fuse_frequency_select = 1'b0;
    logic [6:0]  trim_lo = 7'h00;
    logic [6:0]  trim_hi = 7'h00;
    logic [3:0]  temp_lo = 4'h0;
    logic [3:0]  temp_hi = 4'h0;
    logic [3:0]  osc_level = 4'h0;
    logic        sleep_active = 1'b0;
    logic        periph_uses_sysclk = 1'b0;
    logic [7:0]  reg_rdata;
    logic        main_clock;
    logic        peripheral_clock;
    logic        system_clock_pin;
    logic        fast_osc_power;
    logic        rd_pend = 1'b0;
    logic [15:0] note;
    logic [15:0] exp_q[$];
    logic [3:0]  codes[14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h6, 4'h7, 4'hF};
    int          ratios[14] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 2, 2, 2};
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [6:0]  t;
    logic [7:0]  pv;

    mcsp_main_clock DUT (
        .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .change_protection,
        .fuse_calibration_lock, .fuse_frequency_select, .factory_trim_lo(trim_lo), .factory_trim_hi(trim_hi),
        .factory_temp_lo(temp_lo), .factory_temp_hi(temp_hi), .osc_level, .osc_ready(4'hF),
        .periph_request(4'h0), .sleep_active, .periph_uses_sysclk, .main_clock, .peripheral_clock,
        .system_clock_pin, .fast_osc_power, .ulp_osc_power(), .crystal_osc_power(), .crystal_ext_select(),
        .crystal_startup_sel()
    );

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // fast source waveform, eight core cycles a period
    always begin
        repeat (4) @(posedge core_clk);
        osc_level[0] <= ~osc_level[0];
    end

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // read data watcher
    always @(posedge core_clk) begin
        if (rd_pend) begin
            note = exp_q.pop_front();
            check("reg_rdata", {8'h00, note[15:8]}, {8'h00, reg_rdata & note[7:0]});
        end
        rd_pend <= reg_rd;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic cp);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        change_protection <= cp;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        change_protection <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back({e & m, m});
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic do_reset(input logic fl, input logic fs);
        rst_n <= 1'b0;
        fuse_calibration_lock <= fl;
        fuse_frequency_select <= fs;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (80) @(posedge core_clk);
    endtask

    task automatic measure(input int e);
        realtime t0;
        repeat (2) @(posedge peripheral_clock);
        t0 = $realtime;
        @(posedge peripheral_clock);
        check("per_period", 16'(e), 16'(int'(($realtime - t0) / 20.0)));
    endtask

    task automatic pin_seen(input logic e);
        int n;
        n = 0;
        repeat (64) begin
            @(posedge core_clk);
            n += int'(system_clock_pin === 1'b1);
        end
        check("pin_clock", {15'h0, e}, {15'h0, n != 0});
    endtask

    initial begin
        void'($urandom(32'h6202AB37));
        trim_lo = 7'($urandom);
        trim_hi = 7'($urandom);
        temp_lo = 4'($urandom);
        temp_hi = 4'($urandom);
        do_reset(1'b0, 1'b0);
        rd(`MCSP_OFS_MAIN_SRC, 8'h00, 8'hFF);
        rd(`MCSP_OFS_PRESCALE, 8'h11, 8'hFF);
        rd(`MCSP_OFS_STATUS, 8'h10, 8'hFF);
        rd(`MCSP_OFS_FAST_TRIM, {1'b0, trim_lo}, 8'hFF);
        rd(`MCSP_OFS_FAST_TEMP, {4'h0, temp_lo}, 8'hFF);
        rd(5'h05, 8'h00, 8'hFF);
        wr(`MCSP_OFS_PRESCALE, 8'h05, 1'b0);
        rd(`MCSP_OFS_PRESCALE, 8'h11, 8'hFF);
        wr(`MCSP_OFS_FAST_CTRL, 8'h02, 1'b1);
        rd(`MCSP_OFS_FAST_CTRL, 8'h02, 8'hFF);
        check("fast_osc_power", 16'h1, {15'h0, fast_osc_power});
        t = 7'($urandom);
        wr(`MCSP_OFS_FAST_TRIM, {1'b1, t}, 1'b1);
        rd(`MCSP_OFS_FAST_TRIM, {1'b0, t}, 8'hFF);
        for (int i = 0; i < 14; i++) begin
            wr(`MCSP_OFS_PRESCALE, {3'h0, codes[i], 1'b1}, 1'b1);
            measure(8 * ratios[i]);
        end
        pv = {3'h0, 4'($urandom), 1'b0};
        wr(`MCSP_OFS_PRESCALE, pv, 1'b1);
        measure(8);
        wr(`MCSP_OFS_MAIN_SRC, 8'h80, 1'b1);
        pin_seen(1'b1);
        sleep_active <= 1'b1;
        repeat (2) @(posedge core_clk);
        pin_seen(1'b0);
        periph_uses_sysclk <= 1'b1;
        repeat (2) @(posedge core_clk);
        pin_seen(1'b1);
        sleep_active <= 1'b0;
        periph_uses_sysclk <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            wr(`MCSP_OFS_MAIN_SRC, 8'h80 | 8'(s), 1'b1);
            repeat (10) @(posedge core_clk);
            rd(`MCSP_OFS_STATUS, 8'h01, 8'h21);
            rd(`MCSP_OFS_MAIN_SRC, 8'h80 | 8'(s), 8'hFF);
        end
        wr(`MCSP_OFS_MAIN_SRC, 8'h80, 1'b1);
        repeat (80) @(posedge core_clk);
        rd(`MCSP_OFS_STATUS, 8'h10, 8'hFF);
        wr(`MCSP_OFS_LOCK, 8'h01, 1'b1);
        wr(`MCSP_OFS_PRESCALE, 8'h03, 1'b1);
        rd(`MCSP_OFS_PRESCALE, pv, 8'hFF);
        wr(`MCSP_OFS_LOCK, 8'h00, 1'b1);
        rd(`MCSP_OFS_LOCK, 8'h00, 8'hFF);
        wr(`MCSP_OFS_MAIN_SRC, 8'h01, 1'b1);
        rd(`MCSP_OFS_MAIN_SRC, 8'h80, 8'hFF);
        wr(`MCSP_OFS_FAST_TRIM, 8'($urandom), 1'b1);
        rd(`MCSP_OFS_FAST_TRIM, {1'b0, t}, 8'hFF);
        do_reset(1'b1, 1'b1);
        rd(`MCSP_OFS_FAST_TRIM, {1'b0, trim_hi}, 8'hFF);
        rd(`MCSP_OFS_FAST_TEMP, {4'h8, temp_hi}, 8'hFF);
        wr(`MCSP_OFS_PRESCALE, 8'h03, 1'b1);
        rd(`MCSP_OFS_PRESCALE, 8'h11, 8'hFF);
        rd(`MCSP_OFS_MAIN_SRC, 8'h00, 8'hFF);
        repeat (3) @(posedge core_clk);
        complete_run();
    end
endmodule

bind mcsp_main_clock mcsp_main_clock_sva u_chk (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .change_protection,
    .fuse_calibration_lock, .sleep_active, .periph_uses_sysclk, .main_clock, .system_clock_pin, .fast_osc_power
);
